/* File: src/pdw_pkg.sv */
package pdw_pkg;

  // ==========================================================================
  // Mode selector encodings (upper bit, lower bit).
  localparam logic [1:0] SEL_STANDBY = 2'h2;
  localparam logic [1:0] SEL_IDLE    = 2'h1;
  localparam logic [1:0] SEL_QUICK   = 2'h3;

  // ==========================================================================
  // Wake-up timing, in clock cycles.
  localparam int          STAB_BITS     = 18;
  localparam logic [17:0] STAB_NORMAL   = 18'h20000;
  localparam logic [17:0] STAB_QUICK    = 18'h00040;
  localparam logic [17:0] STAB_IDLE     = 18'h00008;
  localparam logic [17:0] STAB_RESET    = 18'h00000;
  localparam logic [19:0] RESET_VECTOR  = 20'h00000;

  typedef enum logic [2:0] {
    PDW_RUN, PDW_SLEEP, PDW_STOP, PDW_WAIT, PDW_BUSREL
  } pdw_state_e;

endpackage : pdw_pkg

/* File: src/pdw_stab_counter.sv */
`timescale 1ns/1ps
module pdw_stab_counter
  import pdw_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic        abort,
  input  wire logic [17:0] limit,
  output logic             done
);
  logic [17:0] count_r;
  logic        run_r;

  // ==========================================================================
  // Counter stops at limit minus one and stays there until restarted.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_r <= STAB_RESET;
      run_r   <= 1'b0;
    end else if (start) begin
      count_r <= STAB_RESET;
      run_r   <= 1'b1;
    end else if (abort) begin
      run_r   <= 1'b0;
    end else if (run_r && !done) begin
      count_r <= count_r + 18'h00001;
    end
  end

  assign done = run_r && (count_r == limit - 18'h00001);
endmodule : pdw_stab_counter

/* File: src/pdw_controller.sv */
// Notes on behaviour
// R1 - Sleep stops core, I/O stop stops peripherals, system stop both; oscillator runs. io_stop only qualifies entry; sleep keeps io_clock_enable on.
// R2 - Selector 10, I/O stop set and sleep instruction enter standby.
// R3 - Standby stops oscillator, internal clocks and clock output.
// R4 - Selector 01 enters idle: oscillator runs, internal and output clocks gated.
// R5 - Selector 11 enters quick standby: standby with shorter wake delay.
// R6 - Standby wake restarts oscillator, counts 2^17 clocks, then resumes clocks.
// R7 - Waking source must hold for whole count, else standby resumes.
// R8 - Reset in standby resumes clocks at once; execution restarts at zero.
// R9 - Reset source holds reset long enough for oscillator to settle.
// R10 - With bus wake enabled, bus request wakes standby after stabilisation.
// R11 - After bus wake, float address and strobes, then grant the bus.
// R12 - On bus request release, drive address and strobes high, leave standby.
// R13 - With bus wake disabled, bus request does not end standby.
// R14 - After reset or interrupt exit, bus stays released while request held.
// R15 - Non-maskable interrupt wakes standby; acknowledge follows clock resume.
// R16 - Non-maskable falling edge is latched so exit completes regardless.
// R17 - A maskable interrupt with its enable clear never wakes standby.
// R18 - Enabled source with global flag set wakes and is acknowledged.
// R19 - Enabled source with global flag clear wakes and resumes after sleep.
// R20 - Maskable source must hold until clocks resume, else no exit.
// R21 - Idle wakes on same sources, eight cycles, no stabilisation count.
// R22 - Quick standby wakes after 64 cycles; oscillator must settle by then.
// R23 - Enter idle or standby only after second sleep opcode, with I/O stop.
`timescale 1ns/1ps
module pdw_controller
  import pdw_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        ext_reset_n,
  input  wire logic [1:0]  standby_idle_select,
  input  wire logic        io_stop,
  input  wire logic        bus_request_wake_enable,
  input  wire logic        sleep_opcode2_fetched,
  input  wire logic        global_interrupt_enable_flag,
  input  wire logic [2:0]  irq_enable,
  input  wire logic        nmi_n,
  input  wire logic        maskable_irq0_n,
  input  wire logic        maskable_irq1_n,
  input  wire logic        maskable_irq2_n,
  input  wire logic        bus_request_n,
  input  wire logic        nmi_ack_done,
  output logic             osc_enable,
  output logic             core_clock_enable,
  output logic             io_clock_enable,
  output logic             system_clock_output_enable,
  output logic             nmi_ack_request,
  output logic             irq_ack_request,
  output logic             resume_after_sleep,
  output logic             bus_grant_n,
  output logic             bus_drive_oe,
  output logic             bus_drive_high,
  output logic             fetch_from_reset_vector,
  output logic [19:0]      reset_vector,
  output logic [1:0]       active_mode
);

  // ==========================================================================
  // Pin synchronisers.
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= 7'h7F;
      pin_s2_r <= 7'h7F;
    end else begin
      pin_s1_r <= {ext_reset_n, nmi_n, maskable_irq2_n, maskable_irq1_n,
                   maskable_irq0_n, bus_request_n, 1'b1};
      pin_s2_r <= pin_s1_r;
    end
  end

  wire       rst_req  = !pin_s2_r[6];
  wire       nmi_lvl  = !pin_s2_r[5];
  wire [2:0] irq_lvl  = ~pin_s2_r[4:2];
  wire       breq     = !pin_s2_r[1];

  // ==========================================================================
  // Wake source qualification.
  logic       nmi_prev_r;
  logic       nmi_latch_r;
  wire        nmi_edge   = nmi_lvl && !nmi_prev_r;
  wire [2:0]  irq_qual   = irq_lvl & irq_enable; // [R17]
  wire        irq_wake   = |irq_qual; // [R18] [R19]
  wire        breq_wake  = breq && bus_request_wake_enable; // [R10] [R13]
  wire        nmi_wake   = nmi_edge || nmi_latch_r; // [R15]
  wire        held_wake  = irq_wake || breq_wake;
  wire        any_wake   = held_wake || nmi_wake;

  // ==========================================================================
  // Mode decode; idle and standby only after the sleep fetch with I/O stop set.
  wire sel_idle    = standby_idle_select == SEL_IDLE;
  wire sel_standby = standby_idle_select == SEL_STANDBY;
  wire sel_quick   = standby_idle_select == SEL_QUICK;
  wire deep_sel    = sel_idle || sel_standby || sel_quick;
  wire enter_deep  = sleep_opcode2_fetched && io_stop && deep_sel; // [R2] [R4] [R5] [R23]
  wire enter_plain = sleep_opcode2_fetched && !enter_deep;

  pdw_state_e  state_r;
  pdw_state_e  state_nxt;
  logic [1:0]  mode_r;
  logic [17:0] limit_r;
  logic        bus_woke_r;
  logic        ack_nmi_r;
  logic        ack_irq_r;
  logic        resume_r;
  logic        vec_r;
  logic        rst_seen_r;

  wire wait_done;
  wire abort_wait = (state_r == PDW_WAIT) && !held_wake && !nmi_latch_r; // [R7] [R20]
  wire start_wait = (state_r == PDW_STOP) && any_wake && !rst_req;

  pdw_stab_counter u_stab (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (start_wait),
    .abort   (abort_wait),
    .limit   (limit_r),
    .done    (wait_done)
  );

  // ==========================================================================
  // Next state.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PDW_RUN:    if (enter_deep) state_nxt = PDW_STOP;
                  else if (enter_plain) state_nxt = PDW_SLEEP;
      PDW_SLEEP:  if (any_wake || rst_req) state_nxt = PDW_RUN; // [R1]
      PDW_STOP:   if (rst_req) state_nxt = breq ? PDW_BUSREL : PDW_RUN; // [R8] [R14]
                  else if (any_wake) state_nxt = PDW_WAIT;
      PDW_WAIT:   if (abort_wait) state_nxt = PDW_STOP; // [R7]
                  else if (wait_done) state_nxt = breq ? PDW_BUSREL : PDW_RUN; // [R6] [R11]
      PDW_BUSREL: if (!breq) state_nxt = PDW_RUN; // [R12] [R14]
      default:    state_nxt = PDW_RUN;
    endcase
  end

  wire leaving = (state_r == PDW_WAIT) && wait_done && !abort_wait;

  // ==========================================================================
  // State and side registers.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r     <= PDW_RUN;
      mode_r      <= 2'h0;
      limit_r     <= STAB_NORMAL;
      nmi_prev_r  <= 1'b0;
      nmi_latch_r <= 1'b0;
      bus_woke_r  <= 1'b0;
      ack_nmi_r   <= 1'b0;
      ack_irq_r   <= 1'b0;
      resume_r    <= 1'b0;
      vec_r       <= 1'b0;
      rst_seen_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      nmi_prev_r <= nmi_lvl;
      // The edge latch survives the input going away before the count ends.
      if (nmi_edge && state_r != PDW_RUN) begin
        nmi_latch_r <= 1'b1; // [R16]
      end else if (state_nxt == PDW_RUN) begin
        nmi_latch_r <= 1'b0;
      end
      if (state_r == PDW_RUN && enter_deep) begin
        mode_r  <= standby_idle_select;
        limit_r <= sel_idle ? STAB_IDLE : (sel_quick ? STAB_QUICK : STAB_NORMAL); // [R21] [R22]
      end
      if (leaving) begin
        bus_woke_r <= breq_wake && breq;
        ack_nmi_r  <= nmi_latch_r || nmi_edge;
        ack_irq_r  <= irq_wake && global_interrupt_enable_flag;
        resume_r   <= irq_wake && !global_interrupt_enable_flag;
      end else begin
        if (nmi_ack_done) ack_nmi_r <= 1'b0;
        if (irq_wake == 1'b0) ack_irq_r <= 1'b0;
        resume_r <= 1'b0;
      end
      // Kept for the first run cycle, so the retaken bus is driven high once.
      if (state_r == PDW_RUN) bus_woke_r <= 1'b0; // [R12]
      if ((state_r == PDW_STOP || state_r == PDW_WAIT) && rst_req) begin
        rst_seen_r <= 1'b1;
      end else if (vec_r) begin
        rst_seen_r <= 1'b0;
      end
      // The restart from the vector waits until the reset pin is released.
      vec_r <= rst_seen_r && !rst_req && !vec_r; // [R8]
    end
  end

  // ==========================================================================
  // Clock and bus outputs.
  wire in_stop  = state_r == PDW_STOP;
  wire in_wait  = state_r == PDW_WAIT;
  wire is_idle  = mode_r == SEL_IDLE;
  wire gated    = in_stop || in_wait;

  assign osc_enable                 = !(in_stop && !is_idle); // [R3] [R4]
  assign core_clock_enable          = !gated && state_r != PDW_SLEEP; // [R1]
  assign io_clock_enable            = !gated; // [R3]
  assign system_clock_output_enable = !gated; // [R3]
  assign nmi_ack_request            = ack_nmi_r; // [R15]
  assign irq_ack_request            = ack_irq_r; // [R18]
  assign resume_after_sleep         = resume_r; // [R19]
  assign bus_grant_n                = !(state_r == PDW_BUSREL); // [R11]
  assign bus_drive_oe               = state_r != PDW_BUSREL; // [R11] [R12]
  assign bus_drive_high             = state_r != PDW_RUN || bus_woke_r; // [R12]
  assign fetch_from_reset_vector    = vec_r;
  assign reset_vector               = RESET_VECTOR;
  assign active_mode                = mode_r;

  // ==========================================================================
  // Checks.
  a_standby_osc_off: assert property (@(posedge sys_clk) disable iff (!resetn) // [R3]
    (in_stop && mode_r == SEL_STANDBY) |-> !osc_enable)
    else $error("oscillator running in standby");
  a_idle_osc_on: assert property (@(posedge sys_clk) disable iff (!resetn) // [R4]
    (gated && is_idle) |-> (osc_enable && !system_clock_output_enable))
    else $error("idle clock gating wrong");
  a_entry_needs_stop: assert property (@(posedge sys_clk) disable iff (!resetn) // [R23]
    (state_r == PDW_RUN && sleep_opcode2_fetched && !io_stop) |=> state_r != PDW_STOP)
    else $error("power-down entered without io stop");
  a_idle_eight: assert property (@(posedge sys_clk) disable iff (!resetn) // [R21]
    (start_wait && is_idle) ##1 held_wake [*8] |=> state_r != PDW_WAIT)
    else $error("idle wake not eight cycles");
  a_quick_wait: assert property (@(posedge sys_clk) disable iff (!resetn) // [R22]
    (start_wait && mode_r == SEL_QUICK) ##1 held_wake[*8] |-> in_wait)
    else $error("quick wake too early");
  a_drop_restop: assert property (@(posedge sys_clk) disable iff (!resetn) // [R7]
    abort_wait |=> in_stop)
    else $error("no return to standby after drop");
  a_busrel_grant: assert property (@(posedge sys_clk) disable iff (!resetn) // [R11]
    (state_r == PDW_BUSREL) |-> (!bus_grant_n && !bus_drive_oe))
    else $error("bus not released");
  a_no_disabled_irq: assert property (@(posedge sys_clk) disable iff (!resetn) // [R17]
    (in_stop && !nmi_wake && !breq_wake && !rst_req && irq_qual == 3'h0) |=> in_stop)
    else $error("woke on disabled source");
  a_bus_request_n_ignored: assert property (@(posedge sys_clk) disable iff (!resetn) // [R13]
    (in_stop && !bus_request_wake_enable && !irq_wake && !nmi_wake && !rst_req) |=> in_stop)
    else $error("bus request woke with enable clear");
  c_standby_wake: cover property (@(posedge sys_clk) disable iff (!resetn) leaving);
  c_bus_release:  cover property (@(posedge sys_clk) disable iff (!resetn)
    state_r == PDW_BUSREL);
  c_abort:        cover property (@(posedge sys_clk) disable iff (!resetn) abort_wait);

endmodule : pdw_controller

/* File: tb/pdw_far_side.sv */
`timescale 1ns/1ps
// ==========================================================================
// External reset, interrupt and bus master pins, all active low.
module pdw_far_side (
  input  wire logic sys_clk,
  input  wire logic nmi_ack_request,
  output logic      ext_reset_n,
  output logic      bus_request_n,
  output logic      maskable_irq2_n,
  output logic      maskable_irq1_n,
  output logic      maskable_irq0_n,
  output logic      nmi_n,
  output logic      nmi_ack_done = 1'b0
);
  // Index 0 nmi, 1 to 3 irq0 to irq2, 4 bus request, 5 reset.
  logic [5:0] lines_n = 6'h3F;
  assign {ext_reset_n, bus_request_n, maskable_irq2_n} = lines_n[5:3];
  assign {maskable_irq1_n, maskable_irq0_n, nmi_n} = lines_n[2:0];
  task automatic set(input int idx, input logic val);
    lines_n[idx] = val;
  endtask : set
  // The acknowledge cycle finishes one clock after it is requested.
  always @(posedge sys_clk) begin
    nmi_ack_done <= #1 nmi_ack_request & ~nmi_ack_done;
  end
endmodule : pdw_far_side

/* File: tb/power_down_wake_controller_tb.sv */
`timescale 1ns/1ps
module power_down_wake_controller_tb
  import pdw_pkg::*;
;
  logic        sys_clk = 1'b0, resetn = 1'b0, io_stop = 1'b0;
  logic        bus_request_wake_enable = 1'b0, sleep_opcode2_fetched = 1'b0;
  logic        global_interrupt_enable_flag = 1'b0;
  logic [1:0]  standby_idle_select = 2'h0;
  logic [2:0]  irq_enable = 3'h0;
  logic        ext_reset_n, nmi_n, maskable_irq0_n, maskable_irq1_n, maskable_irq2_n;
  logic        bus_request_n, nmi_ack_done, osc_enable, core_clock_enable, io_clock_enable;
  logic        system_clock_output_enable, nmi_ack_request, irq_ack_request;
  logic        resume_after_sleep, bus_grant_n, bus_drive_oe, bus_drive_high;
  logic        fetch_from_reset_vector;
  logic [19:0] reset_vector;
  logic [1:0]  active_mode;
  int          err_count = 0, total_checks = 0, n, resumes = 0, acks = 0, a0;
  always #20 sys_clk = ~sys_clk;
  pdw_controller pdw_controller_inst (
    .sys_clk(sys_clk), .resetn(resetn), .ext_reset_n(ext_reset_n),
    .standby_idle_select(standby_idle_select), .io_stop(io_stop),
    .bus_request_wake_enable(bus_request_wake_enable),
    .sleep_opcode2_fetched(sleep_opcode2_fetched),
    .global_interrupt_enable_flag(global_interrupt_enable_flag), .irq_enable(irq_enable),
    .nmi_n(nmi_n), .maskable_irq0_n(maskable_irq0_n), .maskable_irq1_n(maskable_irq1_n),
    .maskable_irq2_n(maskable_irq2_n), .bus_request_n(bus_request_n),
    .nmi_ack_done(nmi_ack_done), .osc_enable(osc_enable),
    .core_clock_enable(core_clock_enable), .io_clock_enable(io_clock_enable),
    .system_clock_output_enable(system_clock_output_enable),
    .nmi_ack_request(nmi_ack_request), .irq_ack_request(irq_ack_request),
    .resume_after_sleep(resume_after_sleep), .bus_grant_n(bus_grant_n),
    .bus_drive_oe(bus_drive_oe), .bus_drive_high(bus_drive_high),
    .fetch_from_reset_vector(fetch_from_reset_vector), .reset_vector(reset_vector),
    .active_mode(active_mode));
  pdw_far_side   pdw_far_side_inst (
    .sys_clk(sys_clk), .nmi_ack_request(nmi_ack_request), .ext_reset_n(ext_reset_n),
    .bus_request_n(bus_request_n), .maskable_irq2_n(maskable_irq2_n),
    .maskable_irq1_n(maskable_irq1_n), .maskable_irq0_n(maskable_irq0_n),
    .nmi_n(nmi_n), .nmi_ack_done(nmi_ack_done));
  always @(posedge sys_clk) begin
    if (resume_after_sleep === 1'b1) resumes++;
    if (nmi_ack_request === 1'b1) acks++;
  end
  // ==========================================================================
  // Shared helpers.
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic enter(input logic [1:0] sel, input logic stop);
    standby_idle_select = sel;
    io_stop = stop;
    sleep_opcode2_fetched = 1'b1;
    cyc(1);
    sleep_opcode2_fetched = 1'b0;
    cyc(2);
  endtask : enter
  // Bounded wait for the core clock, then the wait must fall in lo..hi.
  task automatic wake_in(input int lo, input int hi);
    n = 0;
    while (core_clock_enable !== 1'b1 && n <= hi) begin
      cyc(1);
      n++;
    end
    chk(20'(n >= lo && n <= hi), 20'h1);
  endtask : wake_in
  function automatic logic [19:0] clks();
    return 20'({osc_enable, core_clock_enable, io_clock_enable, system_clock_output_enable});
  endfunction : clks
  // ==========================================================================
  // Scenarios.
  task automatic sc_idle;
    irq_enable = 3'h1;
    global_interrupt_enable_flag = 1'b1;
    enter(SEL_IDLE, 1'b1);
    chk(clks(), 20'h8);
    chk(20'(active_mode), 20'(SEL_IDLE));
    pdw_far_side_inst.set(1, 1'b0);
    wake_in(8, 16);
    cyc(1);
    chk(20'(irq_ack_request), 20'h1);
    pdw_far_side_inst.set(1, 1'b1);
    cyc(4);
  endtask : sc_idle
  task automatic sc_quick;
    irq_enable = 3'h2;
    global_interrupt_enable_flag = 1'b0;
    a0 = resumes;
    enter(SEL_QUICK, 1'b1);
    chk(clks(), 20'h0);
    pdw_far_side_inst.set(2, 1'b0);
    wake_in(64, 76);
    cyc(2);
    chk(20'(resumes == a0 + 1 && irq_ack_request === 1'b0), 20'h1);
    pdw_far_side_inst.set(2, 1'b1);
    cyc(4);
  endtask : sc_quick
  task automatic sc_refuse;
    irq_enable = 3'h3;
    global_interrupt_enable_flag = 1'b1;
    enter(SEL_QUICK, 1'b1);
    pdw_far_side_inst.set(3, 1'b0);
    pdw_far_side_inst.set(1, 1'b0);
    cyc(30);
    pdw_far_side_inst.set(1, 1'b1);
    cyc(100);
    chk(clks(), 20'h0);
    a0 = acks;
    pdw_far_side_inst.set(0, 1'b0);
    cyc(10);
    pdw_far_side_inst.set(0, 1'b1);
    wake_in(50, 70);
    cyc(4);
    chk(20'(acks > a0), 20'h1);
    pdw_far_side_inst.set(3, 1'b1);
    cyc(4);
  endtask : sc_refuse
  task automatic sc_bus;
    irq_enable = 3'h1;
    enter(SEL_QUICK, 1'b1);
    pdw_far_side_inst.set(4, 1'b0);
    cyc(100);
    chk(clks(), 20'h0);
    pdw_far_side_inst.set(1, 1'b0);
    wake_in(64, 76);
    cyc(2);
    chk(20'(bus_grant_n), 20'h0);
    pdw_far_side_inst.set(1, 1'b1);
    pdw_far_side_inst.set(4, 1'b1);
    cyc(6);
    bus_request_wake_enable = 1'b1;
    enter(SEL_QUICK, 1'b1);
    pdw_far_side_inst.set(4, 1'b0);
    wake_in(64, 76);
    cyc(2);
    chk(20'({bus_grant_n, bus_drive_oe}), 20'h0);
    pdw_far_side_inst.set(4, 1'b1);
    n = 0;
    while (bus_grant_n !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(20'({bus_grant_n, bus_drive_oe, bus_drive_high}), 20'h7);
    cyc(4);
    bus_request_wake_enable = 1'b0;
  endtask : sc_bus
  task automatic sc_standby;
    enter(SEL_STANDBY, 1'b1);
    chk(clks(), 20'h0);
    pdw_far_side_inst.set(5, 1'b0);
    wake_in(0, 10);
    cyc(20);
    pdw_far_side_inst.set(5, 1'b1);
    n = 0;
    while (fetch_from_reset_vector !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk({19'h0, fetch_from_reset_vector}, 20'h1);
    chk(reset_vector, 20'h00000);
    cyc(4);
  endtask : sc_standby
  task automatic sc_sleep;
    enter(SEL_IDLE, 1'b0);
    chk(clks(), 20'hB);
    pdw_far_side_inst.set(1, 1'b0);
    wake_in(0, 16);
    pdw_far_side_inst.set(1, 1'b1);
    cyc(4);
  endtask : sc_sleep
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 resetn = 1'b1;
    cyc(2);
    sc_idle();
    sc_quick();
    sc_refuse();
    sc_bus();
    sc_standby();
    sc_sleep();
    final_report();
  end
  // The scenarios need about 620 cycles; eight times that means a hang.
  initial begin
    #200000;
    err_count++;
    final_report();
  end
endmodule : power_down_wake_controller_tb
